/* hdl/arpt_sync2.sv */
// Purpose: Two-flop synchroniser for asynchronous trigger inputs
// Assumes: Inputs are slow compared with ref_clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none

module arpt_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // Asynchronous levels
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // arpt_sync2

`default_nettype wire

/* hdl/arpt_trigger.sv */
// Purpose: Stop (reference) and hold (pause) trigger control for acquisition
// Assumes: Sample strobe and peer triggers are on ref_clk; pins are asynchronous
// Notes: Drives write enable and address of an external sample buffer
`timescale 1ns/1ns
`default_nettype none
`include "arpt_regs.svh"

module arpt_trigger
  import arpt_pkg::*;
(
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic acq_start, // Start pulse
  input wire logic acq_abort, // Abort pulse
  input wire arpt_cfg_type cfg_in, // Settings, taken at start
  input wire arpt_route_type route_in, // Output routing
  input wire logic acq_sample_strobe, // Internal sample clock tick
  input wire logic [`ARPT_NUM_PFI-1:0] programmable_function_pin_i, // Pin levels
  input wire logic [`ARPT_NUM_BUS-1:0] bus_trigger_line_i, // Bus line levels
  input wire logic backplane_star_line_i, // Star line level
  input wire logic analog_compare_event, // Comparator output
  input wire logic [`ARPT_NUM_CTR-1:0] counter_out, // Counter outputs
  input wire logic [`ARPT_NUM_CTR-1:0] counter_gate, // Counter gates
  input wire logic [`ARPT_NUM_PEER-1:0] peer_stop_trig, // Other engines' triggers
  input wire logic [`ARPT_NUM_PEER-1:0] peer_hold_trig, // Other hold triggers
  output var arpt_wr_type buf_wr, // Buffer write strobe and slot
  output var arpt_status_type status, // Status for software
  output logic acq_stop_trigger, // Accepted stop pulse
  output logic acq_hold_trigger, // Hold active level
  output logic [`ARPT_NUM_PFI-1:0] programmable_function_pin_o, // Pin drive
  output logic [`ARPT_NUM_PFI-1:0] programmable_function_pin_oe, // Pin enable
  output logic [`ARPT_NUM_BUS-1:0] bus_trigger_line_o, // Bus line drive
  output logic [`ARPT_NUM_BUS-1:0] bus_trigger_line_oe, // Bus line enable
  output logic [`ARPT_NUM_BP-1:0] backplane_trigger_line_o, // Backplane drive
  output logic [`ARPT_NUM_BP-1:0] backplane_trigger_line_oe, // Backplane enable
  output logic backplane_star_line_o, // Star line drive
  output logic backplane_star_line_oe, // Star line enable
  output logic star_trigger_output // Star output
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PRE,
    ST_ARMED,
    ST_POST
  } arpt_state_type;

  arpt_state_type state_r;
  arpt_state_type state_nxt;
  arpt_cfg_type cfg_r;

  logic [`ARPT_NUM_PFI-1:0] pfi_s;
  logic [`ARPT_NUM_BUS-1:0] bus_s;
  logic star_s;
  logic cmp_s;

  logic [`ARPT_SRC_VEC_W-1:0] stop_vec;
  logic [`ARPT_SRC_VEC_W-1:0] hold_vec;
  logic stop_lvl;
  logic stop_prev_r;
  logic stop_edge;
  logic hold_lvl;
  logic hold_act;
  logic running;
  logic store;
  logic accept;
  logic finish;
  logic start_ok;

  logic [`ARPT_BUF_AW-1:0] addr_r;
  logic [`ARPT_BUF_AW-1:0] addr_nxt;
  logic [`ARPT_BUF_AW-1:0] pre_seen_r;
  logic [`ARPT_BUF_AW-1:0] post_left_r;
  logic [`ARPT_BUF_AW-1:0] post_need;

  // Pin-side inputs and the comparator only; peer and counter signals share ref_clk
  arpt_sync2 #(
    .WIDTH(`ARPT_NUM_PFI)
  ) u_sync_pfi (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(programmable_function_pin_i),
    .sync_out(pfi_s)
  );

  arpt_sync2 #(
    .WIDTH(`ARPT_NUM_BUS)
  ) u_sync_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(bus_trigger_line_i),
    .sync_out(bus_s)
  );

  arpt_sync2 #(
    .WIDTH(1)
  ) u_sync_star (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(backplane_star_line_i),
    .sync_out(star_s)
  );

  arpt_sync2 #(
    .WIDTH(1)
  ) u_sync_cmp (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(analog_compare_event),
    .sync_out(cmp_s)
  );

  // Source vectors, unused codes read as zero
  always_comb begin
    stop_vec = '0;
    hold_vec = '0;
    stop_vec[`ARPT_SRC_PFI_LSB +: `ARPT_NUM_PFI] = pfi_s;
    stop_vec[`ARPT_SRC_BUS_LSB +: `ARPT_NUM_BUS] = bus_s;
    stop_vec[`ARPT_SRC_STAR] = star_s;
    stop_vec[`ARPT_SRC_CMP] = cmp_s;
    stop_vec[`ARPT_SRC_CTR_OUT_LSB +: `ARPT_NUM_CTR] = counter_out;
    stop_vec[`ARPT_SRC_PEER_LSB +: `ARPT_NUM_PEER] = peer_stop_trig;
    hold_vec[`ARPT_SRC_PFI_LSB +: `ARPT_NUM_PFI] = pfi_s;
    hold_vec[`ARPT_SRC_BUS_LSB +: `ARPT_NUM_BUS] = bus_s;
    hold_vec[`ARPT_SRC_STAR] = star_s;
    hold_vec[`ARPT_SRC_CMP] = cmp_s;
    hold_vec[`ARPT_SRC_CTR_OUT_LSB +: `ARPT_NUM_CTR] = counter_out;
    hold_vec[`ARPT_SRC_CTR_GATE_LSB +: `ARPT_NUM_CTR] = counter_gate;
    hold_vec[`ARPT_SRC_PEER_LSB +: `ARPT_NUM_PEER] = peer_hold_trig;
  end

  // Stop edge detection on the frozen source selection
  always_comb begin
    stop_lvl = stop_vec[cfg_r.stop_src];
    if (cfg_r.stop_src == `ARPT_SRC_W'(`ARPT_SRC_CMP)) begin
      stop_edge = stop_lvl & ~stop_prev_r;
    end else if (cfg_r.stop_falling) begin
      stop_edge = ~stop_lvl & stop_prev_r;
    end else begin
      stop_edge = stop_lvl & ~stop_prev_r;
    end
  end

  // Hold is a pure level compare, no edge history kept
  always_comb begin
    hold_lvl = hold_vec[cfg_r.hold_src];
    hold_act = cfg_r.hold_en & (hold_lvl == cfg_r.hold_active_high);
  end

  always_comb begin
    running = (state_r != ST_IDLE);
    store = acq_sample_strobe & running & ~hold_act & ~acq_abort;
    accept = (state_r == ST_ARMED) & stop_edge & ~acq_abort;
    start_ok = (state_r == ST_IDLE) & acq_start & (cfg_in.buf_size != `ARPT_ADDR_ZERO);
    if (addr_r == cfg_r.buf_size - `ARPT_ADDR_ONE) begin
      addr_nxt = `ARPT_ADDR_ZERO;
    end else begin
      addr_nxt = addr_r + `ARPT_ADDR_ONE;
    end
    if (cfg_in.buf_size > cfg_in.pre_count) begin
      post_need = cfg_in.buf_size - cfg_in.pre_count;
    end else begin
      post_need = `ARPT_ADDR_ZERO;
    end
  end

  // Completion: last posttrigger sample, or trigger with no posttrigger room
  always_comb begin
    finish = 1'b0;
    if (state_r == ST_POST && store && post_left_r == `ARPT_ADDR_ONE) begin
      finish = 1'b1;
    end else if (accept && post_left_r == `ARPT_ADDR_ZERO) begin
      finish = 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_ok) begin
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        if (pre_seen_r == cfg_r.pre_count) begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (accept) begin
          state_nxt = finish ? ST_IDLE : ST_POST;
        end
      end
      ST_POST: begin
        if (finish) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    if (acq_abort) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Settings are latched only when idle and starting
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_r <= '0;
    end else if (start_ok) begin
      cfg_r <= cfg_in;
    end
  end

  // Edge history; primed at start so an already-high level is no edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stop_prev_r <= 1'b0;
    end else if (start_ok) begin
      stop_prev_r <= stop_vec[cfg_in.stop_src];
    end else begin
      stop_prev_r <= stop_lvl;
    end
  end

  // Circular write pointer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_r <= `ARPT_ADDR_ZERO;
    end else if (start_ok) begin
      addr_r <= `ARPT_ADDR_ZERO;
    end else if (store) begin
      addr_r <= addr_nxt;
    end
  end

  // Pretrigger fill count, saturating at the programmed figure
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pre_seen_r <= `ARPT_ADDR_ZERO;
    end else if (start_ok) begin
      pre_seen_r <= `ARPT_ADDR_ZERO;
    end else if (store && state_r == ST_PRE && pre_seen_r != cfg_r.pre_count) begin
      pre_seen_r <= pre_seen_r + `ARPT_ADDR_ONE;
    end
  end

  // Posttrigger samples still owed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      post_left_r <= `ARPT_ADDR_ZERO;
    end else if (start_ok) begin
      post_left_r <= post_need;
    end else if (store && state_r == ST_POST) begin
      post_left_r <= post_left_r - `ARPT_ADDR_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_wr <= '0;
    end else begin
      buf_wr.we <= store;
      buf_wr.addr <= addr_r;
    end
  end

  // Status; a sample stored with the trigger counts as pretrigger
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status.busy <= (state_nxt != ST_IDLE);
      status.armed <= (state_nxt == ST_ARMED);
      status.holding <= hold_act & running;
      if (start_ok) begin
        status.done <= 1'b0;
        status.triggered <= 1'b0;
      end else begin
        if (accept) begin
          status.triggered <= 1'b1;
          status.trig_pos <= store ? addr_nxt : addr_r;
        end
        if (finish) begin
          status.done <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acq_stop_trigger <= 1'b0;
      acq_hold_trigger <= 1'b0;
    end else begin
      acq_stop_trigger <= accept;
      acq_hold_trigger <= hold_act & running;
    end
  end

  // Pin drive; a PFI pin or bus line routed both ways carries the stop pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      programmable_function_pin_o <= '0;
      programmable_function_pin_oe <= '0;
      bus_trigger_line_o <= '0;
      bus_trigger_line_oe <= '0;
      backplane_trigger_line_o <= '0;
      backplane_trigger_line_oe <= '0;
      backplane_star_line_o <= 1'b0;
      backplane_star_line_oe <= 1'b0;
      star_trigger_output <= 1'b0;
    end else begin
      programmable_function_pin_oe <= route_in.pfi_stop | route_in.pfi_hold;
      programmable_function_pin_o <= (route_in.pfi_stop & {`ARPT_NUM_PFI{accept}}) |
        (route_in.pfi_hold & ~route_in.pfi_stop & {`ARPT_NUM_PFI{hold_act & running}});
      bus_trigger_line_oe <= route_in.bus_stop | route_in.bus_hold;
      bus_trigger_line_o <= (route_in.bus_stop & {`ARPT_NUM_BUS{accept}}) |
        (route_in.bus_hold & ~route_in.bus_stop & {`ARPT_NUM_BUS{hold_act & running}});
      backplane_trigger_line_oe <= route_in.bp_stop;
      backplane_trigger_line_o <= route_in.bp_stop & {`ARPT_NUM_BP{accept}};
      backplane_star_line_oe <= route_in.star_line_hold;
      backplane_star_line_o <= route_in.star_line_hold & hold_act & running;
      star_trigger_output <= (route_in.star_out_stop & accept) |
        (route_in.star_out_hold & hold_act & running);
    end
  end

endmodule // arpt_trigger

`default_nettype wire

/* pkg/arpt_pkg.sv */
// Purpose: Types for the acquisition stop and hold trigger block
// Assumes: arpt_regs.svh holds all widths
// Notes: Configuration is sampled only at acquisition start
`include "arpt_regs.svh"

package arpt_pkg;

  typedef struct packed {
    logic [`ARPT_BUF_AW-1:0] buf_size;
    logic [`ARPT_BUF_AW-1:0] pre_count;
    logic [`ARPT_SRC_W-1:0] stop_src;
    logic stop_falling;
    logic hold_en;
    logic [`ARPT_SRC_W-1:0] hold_src;
    logic hold_active_high;
  } arpt_cfg_type;

  typedef struct packed {
    logic [`ARPT_NUM_PFI-1:0] pfi_stop;
    logic [`ARPT_NUM_PFI-1:0] pfi_hold;
    logic [`ARPT_NUM_BUS-1:0] bus_stop;
    logic [`ARPT_NUM_BUS-1:0] bus_hold;
    logic [`ARPT_NUM_BP-1:0] bp_stop;
    logic star_line_hold;
    logic star_out_stop;
    logic star_out_hold;
  } arpt_route_type;

  typedef struct packed {
    logic busy;
    logic armed;
    logic triggered;
    logic done;
    logic holding;
    logic [`ARPT_BUF_AW-1:0] trig_pos;
  } arpt_status_type;

  typedef struct packed {
    logic we;
    logic [`ARPT_BUF_AW-1:0] addr;
  } arpt_wr_type;

endpackage

/* pkg/arpt_regs.svh */
// Purpose: Constants for the acquisition stop and hold trigger block
// Assumes: Included by the package and the design files
// Notes: Source select codes index one flat source vector
`ifndef ARPT_REGS_SVH
`define ARPT_REGS_SVH

`define ARPT_BUF_AW 16
`define ARPT_SRC_W 6
`define ARPT_SRC_VEC_W 64
`define ARPT_NUM_PFI 16
`define ARPT_NUM_BUS 8
`define ARPT_NUM_BP 8
`define ARPT_NUM_CTR 4
`define ARPT_NUM_PEER 3

`define ARPT_SRC_PFI_LSB 0
`define ARPT_SRC_BUS_LSB 16
`define ARPT_SRC_STAR 24
`define ARPT_SRC_CMP 25
`define ARPT_SRC_CTR_OUT_LSB 26
`define ARPT_SRC_CTR_GATE_LSB 30
`define ARPT_SRC_PEER_LSB 34

`define ARPT_ADDR_ZERO 16'h0000
`define ARPT_ADDR_ONE 16'h0001

`endif

/* sim/arpt_buf_model.sv */
// Purpose: Sample buffer behind the block's write port
// Assumes: One write per stored sample, slot chosen by the block
// Notes: Only counts writes; contents do not matter to the bench
`timescale 1ns/1ns
`default_nettype none
module arpt_buf_model
  import arpt_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire arpt_wr_type buf_wr, // Write port
  output logic [15:0] wr_count // Writes so far
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_count <= 16'h0000;
    end else if (buf_wr.we) begin
      wr_count <= wr_count + 16'h0001;
    end
  end
endmodule // arpt_buf_model
`default_nettype wire

/* sim/arpt_trigger_sva.sv */
// Purpose: Port checker for arpt_trigger
// Assumes: Bound to arpt_trigger from the bench top
// Notes: Size and pretrigger are shadowed at each accepted start
`timescale 1ns/1ns
`default_nettype none
`include "arpt_regs.svh"
module arpt_trigger_sva
  import arpt_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic acq_start, // Start
  input wire logic acq_abort, // Abort
  input wire arpt_cfg_type cfg_in, // Settings
  input wire arpt_route_type route_in, // Routing
  input wire logic acq_sample_strobe, // Sample tick
  input wire arpt_wr_type buf_wr, // Buffer write
  input wire arpt_status_type status, // Status
  input wire logic acq_stop_trigger, // Stop pulse
  input wire logic acq_hold_trigger, // Hold level
  input wire logic [`ARPT_NUM_PFI-1:0] programmable_function_pin_oe // Pin enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] size_r;
  logic [15:0] pre_r;
  logic [15:0] last_r;
  logic [15:0] wcnt_r;
  logic [15:0] pc_r;
  logic seen_r;
  wire logic go = acq_start && !status.busy && !acq_abort && cfg_in.buf_size != 16'h0000;
  always_ff @(posedge ref_clk) begin
    if (rst || go) begin
      size_r <= cfg_in.buf_size;
      pre_r <= cfg_in.pre_count;
      wcnt_r <= 16'h0000;
      pc_r <= 16'h0000;
      seen_r <= 1'b0;
    end else if (buf_wr.we) begin
      wcnt_r <= wcnt_r + 16'h0001;
      pc_r <= pc_r + ((status.triggered && !acq_stop_trigger) ? 16'h0001 : 16'h0000);
      seen_r <= 1'b1;
    end
  end
  // Last slot kept apart so a start never disturbs it
  always_ff @(posedge ref_clk) begin
    if (buf_wr.we) begin
      last_r <= buf_wr.addr;
    end
  end
  a_strobe_idle: assert property (acq_sample_strobe && !status.busy |=> !buf_wr.we)
    else $error("write from an idle strobe");
  a_hold_gate: assert property (acq_sample_strobe ##1 status.holding |-> !buf_wr.we)
    else $error("write while holding");
  a_addr_wrap: assert property (buf_wr.we |-> buf_wr.addr == ((!seen_r ||
    last_r == size_r - 16'h0001) ? 16'h0000 : last_r + 16'h0001))
    else $error("write slot out of order");
  a_stop_once: assert property (acq_stop_trigger |-> $rose(status.triggered))
    else $error("second stop accepted");
  a_stop_after_pre: assert property (acq_stop_trigger |-> wcnt_r >= pre_r)
    else $error("stop before pretrigger filled");
  a_post_count: assert property ($rose(status.done) |->
    pc_r + 16'h0001 == size_r - pre_r)
    else $error("wrong posttrigger count");
  a_done_end: assert property ($rose(status.done) |->
    buf_wr.we && !status.busy && status.triggered)
    else $error("done not tied to last write");
  a_start_busy: assert property (go |=> status.busy && !status.done && !status.triggered)
    else $error("start not taken");
  a_pin_input: assert property ((programmable_function_pin_oe &
    ~$past(route_in.pfi_stop | route_in.pfi_hold)) == 16'h0000)
    else $error("pin driven without routing");
  a_hold_idle: assert property (!status.busy && !$past(status.busy) && !$past(status.busy, 2)
    |-> !acq_hold_trigger)
    else $error("hold shown while idle");
  c_done: cover property ($rose(status.done));
  c_stop: cover property (acq_stop_trigger);
  c_hold: cover property (acq_sample_strobe ##1 status.holding);
endmodule // arpt_trigger_sva
`default_nettype wire

/* sim/arpt_trigger_tb_top.sv */
// Purpose: Self-checking bench for arpt_trigger
// Assumes: All trigger sources sit in one vector indexed by source code
// Notes: Strobes pause around the stop edge so sample counts are exact
`timescale 1ns/1ns
`default_nettype none
module arpt_trigger_tb_top
  import arpt_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic acq_start = 1'b0;
  logic acq_abort = 1'b0;
  logic acq_sample_strobe = 1'b0;
  arpt_cfg_type cfg_in = '0;
  arpt_route_type route_in = '0;
  logic [63:0] src_v = 64'h0;
  logic [63:0] rnd;
  arpt_wr_type buf_wr;
  arpt_status_type status;
  logic acq_stop_trigger;
  logic [15:0] wr_count;
  logic [15:0] pin_oe;
  logic [7:0] bp_o;
  logic [15:0] base;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 28;
  int idx;
  int s;
  logic fl;
  logic hp;
  logic [15:0] addr_q[$];
  logic [15:0] pos_q[$];
  logic [15:0] cnt_q[$];
  int c_src[6] = '{0, 16, 25, 34, 24, 26};
  int c_hsrc[6] = '{30, 25, 35, 1, 31, 17};
  int c_pre[6] = '{2, 0, 3, 1, 2, 4};
  int c_sz[6] = '{5, 3, 4, 2, 3, 5};
  int c_n[6] = '{7, 1, 3, 4, 5, 4};
  always #5 ref_clk = ~ref_clk;
  arpt_trigger DUT (.ref_clk(ref_clk), .rst(rst), .acq_start(acq_start),
    .acq_abort(acq_abort), .cfg_in(cfg_in), .route_in(route_in),
    .acq_sample_strobe(acq_sample_strobe), .programmable_function_pin_i(src_v[15:0]),
    .bus_trigger_line_i(src_v[23:16]), .backplane_star_line_i(src_v[24]),
    .analog_compare_event(src_v[25]), .counter_out(src_v[29:26]),
    .counter_gate(src_v[33:30]), .peer_stop_trig(src_v[36:34]),
    .peer_hold_trig(src_v[36:34]), .buf_wr(buf_wr), .status(status),
    .acq_stop_trigger(acq_stop_trigger), .acq_hold_trigger(),
    .programmable_function_pin_o(), .programmable_function_pin_oe(pin_oe),
    .bus_trigger_line_o(), .bus_trigger_line_oe(), .backplane_trigger_line_o(bp_o),
    .backplane_trigger_line_oe(), .backplane_star_line_o(), .backplane_star_line_oe(),
    .star_trigger_output());
  arpt_buf_model u_buf (.ref_clk(ref_clk), .rst(rst), .buf_wr(buf_wr), .wr_count(wr_count));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Expected slots are queued only for strobes that must store
  task automatic strobes(input int n, input logic keep, input int sz);
    for (int i = 0; i < n; i++) begin
      acq_sample_strobe <= 1'b1;
      if (keep) addr_q.push_back(16'(idx % sz));
      if (keep) idx++;
      tick(1);
      acq_sample_strobe <= 1'b0;
      tick(1 + ($random(seed) & 1));
    end
  endtask
  always @(posedge ref_clk) begin
    if (!rst && buf_wr.we) begin
      if (addr_q.size() == 0) chk("write slot", 16'hFFFF, buf_wr.addr);
      else chk("write slot", addr_q.pop_front(), buf_wr.addr);
    end
    if (!rst && status.done === 1'b1 && pos_q.size() != 0) begin
      chk("trigger slot", pos_q.pop_front(), status.trig_pos);
      chk("write count", cnt_q.pop_front(), wr_count + 16'h0001);
    end
    if (!rst && acq_stop_trigger === 1'b1) begin
      chk("backplane drive", {8'h00, route_in.bp_stop}, {8'h00, bp_o});
    end
  end
  initial begin
    tick(20000);
    num_errors++;
    stop_test();
  end
  initial begin
    tick(16);
    chk("pin enable at reset", 16'h0000, pin_oe);
    rst <= 1'b0;
    for (int c = 0; c < 6; c++) begin
      s = (c == 0) ? ($random(seed) & 15) : c_src[c];
      fl = c[0] && s != 25;
      hp = 1'($random(seed) & 1);
      rnd = {$random(seed), $random(seed)};
      src_v[s] <= fl;
      src_v[c_hsrc[c]] <= !hp;
      route_in <= rnd[58:0];
      cfg_in <= '{16'(c_sz[c]), 16'(c_pre[c]), 6'(s), fl, 1'b1, 6'(c_hsrc[c]), hp};
      tick(1);
      strobes(2, 1'b0, 1);
      tick(3);
      base = wr_count;
      idx = 0;
      acq_start <= 1'b1;
      tick(1);
      acq_start <= 1'b0;
      cfg_in <= rnd[46:0];
      if (c_pre[c] > 0) begin
        src_v[s] <= !fl;
        tick(3);
        src_v[s] <= fl;
        tick(3);
      end
      src_v[c_hsrc[c]] <= hp;
      tick(3);
      strobes(3, 1'b0, c_sz[c]);
      src_v[c_hsrc[c]] <= !hp;
      tick(3);
      strobes(c_n[c], 1'b1, c_sz[c]);
      for (int k = 0; k < 30 && status.armed !== 1'b1; k++) tick(1);
      src_v[s] <= !fl;
      for (int k = 0; k < 30 && acq_stop_trigger !== 1'b1; k++) tick(1);
      pos_q.push_back(16'(c_n[c] % c_sz[c]));
      cnt_q.push_back(base + 16'(c_n[c] + c_sz[c] - c_pre[c]));
      // Second stop edge while collecting posttrigger samples must be ignored
      src_v[s] <= fl;
      tick(3);
      src_v[s] <= !fl;
      tick(4);
      strobes(c_sz[c] - c_pre[c], 1'b1, c_sz[c]);
      for (int k = 0; k < 30 && status.done !== 1'b1; k++) tick(1);
      tick(2);
      chk("pin enable", route_in.pfi_stop | route_in.pfi_hold, pin_oe);
      $display("test %0d source %0d ended", c, s);
    end
    tick(5);
    // A lost trigger or completion leaves notes behind
    chk("results left over", 16'h0000, 16'(pos_q.size() + addr_q.size() + cnt_q.size()));
    stop_test();
  end
endmodule // arpt_trigger_tb_top
bind arpt_trigger arpt_trigger_sva u_sva (.*);
`default_nettype wire
